// ===== image_stats_pixel_grabber.sv
// How it works
// R1 - exposure main_tick count, sixteen bits, two bytes
// R2 - software reads upper byte before lower
// R3 - peak register: max pixel, bit 7 zero
// R4 - 17-bit pixel sum, bits 15:8 exposed
// R5 - floor register: min pixel, bit 7 zero
// R6 - armed grabber captures one pixel per frame
// R7 - held pixel read sets bit 7, advances
// R8 - software does 361 valid grab reads
// R9 - grab write with byte 0 strobe set resets index, arms
// R10 - indices run down columns from top right
// R11 - flipped revision is complement of revision
// R12 - fuse setup bit 0 gates fuse commands
// R13 - upper read latches matching lower byte
`timescale 1ns/1ps
`include "image_stats_defs.svh"

module image_stats_pixel_grabber import image_stats_pkg::*; #(
  parameter logic [7:0] REV_CODE = 8'h5A  // arbitrary value
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                main_tick,
  input  wire logic                shutter_open,
  input  wire logic                frame_start,
  input  wire pixel_in_t           pix,
  output logic                     fuse_cmd_enable,
  input  wire logic [`ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [`ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  logic [8:0]   pix_index;
  frame_stats_t stats;

  // R10 stream order
  // pixels arrive in index order, down each column from the top right
  pixel_stats_engine u_stats (
    .clk         (clk),
    .rst_n       (rst_n),
    .frame_start (frame_start),
    .pix         (pix),
    .pix_index   (pix_index),
    .stats       (stats)
  );

  // exposure count
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] exposure_reg, exposure_next;
  logic        open_d_reg;

  always_comb begin
    cnt_next      = cnt_reg;
    exposure_next = exposure_reg;
    if (shutter_open && main_tick) begin
      cnt_next = cnt_reg + 16'h0001;
    end
    // R1 latch on close
    if (open_d_reg && !shutter_open) begin
      exposure_next = cnt_reg;
      cnt_next      = 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg      <= 16'h0000;
      exposure_reg <= `EXPOSURE_RESET;
      open_d_reg   <= 1'b0;
    end else begin
      cnt_reg      <= cnt_next;
      exposure_reg <= exposure_next;
      open_d_reg   <= shutter_open;
    end
  end

  // write channel
  logic                aw_held_reg, aw_held_next;
  logic                w_held_reg, w_held_next;
  logic [`ADDR_W-1:0]  waddr_reg, waddr_next;
  logic [31:0]         wdata_reg, wdata_next;
  logic                wstrb0_reg, wstrb0_next;
  logic                bvalid_next;
  logic [1:0]          bresp_next;
  logic                do_write;
  logic [7:0]          w_idx;
  logic                w_mapped;

  // read channel
  logic                rvalid_next;
  logic [31:0]         rdata_next;
  logic [1:0]          rresp_next;
  logic                ar_take;
  logic [7:0]          r_idx;
  logic                r_addr_ok;
  logic [7:0]          rd_idx_reg;

  // register state
  grab_state_t         grab_state_reg, grab_state_next;
  logic [8:0]          grab_idx_reg, grab_idx_next;
  logic [6:0]          grab_val_reg, grab_val_next;
  logic                fuse_next;
  logic [7:0]          lo_shadow_reg, lo_shadow_next;
  logic                lo_pending_reg, lo_pending_next;

  assign w_idx     = waddr_reg[9:2];
  assign w_mapped  = (waddr_reg[11:10] == 2'b00) &&
                     (w_idx == `IDX_GRAB || w_idx == `IDX_FUSE_SETUP);
  assign do_write  = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign r_idx     = s_axi_araddr[9:2];
  assign r_addr_ok = (s_axi_araddr[11:10] == 2'b00);
  assign ar_take   = s_axi_arvalid && s_axi_arready;

  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    waddr_next   = waddr_reg;
    wdata_next   = wdata_reg;
    wstrb0_next  = wstrb0_reg;
    bresp_next   = s_axi_bresp;
    bvalid_next  = s_axi_bvalid && !s_axi_bready;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      waddr_next   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb0_next = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      // read-only and unknown registers alike refuse writes
      bresp_next   = w_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  always_comb begin
    rdata_next      = s_axi_rdata;
    rresp_next      = s_axi_rresp;
    rvalid_next     = s_axi_rvalid && !s_axi_rready;
    grab_state_next = grab_state_reg;
    grab_idx_next   = grab_idx_reg;
    grab_val_next   = grab_val_reg;
    fuse_next       = fuse_cmd_enable;
    lo_shadow_next  = lo_shadow_reg;
    lo_pending_next = lo_pending_reg;

    // R6 one capture per frame
    if (grab_state_reg == GRAB_ARMED && pix.valid && pix_index == grab_idx_reg) begin
      grab_state_next = GRAB_HELD;
      grab_val_next   = pix.value;
    end

    if (ar_take) begin
      rvalid_next = 1'b1;
      rresp_next  = `RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      if (!r_addr_ok) begin
        rresp_next = `RESP_SLVERR;
      end else begin
        unique case (r_idx)
          `IDX_REVISION: rdata_next[7:0] = REV_CODE;
          `IDX_EXPOSURE_UPPER: begin
            // R13 freeze lower half
            rdata_next[7:0] = exposure_reg[15:8];
            lo_shadow_next  = exposure_reg[7:0];
            lo_pending_next = 1'b1;
          end
          `IDX_EXPOSURE_LOWER: begin
            // R13 serve frozen half
            rdata_next[7:0] = lo_pending_reg ? lo_shadow_reg : exposure_reg[7:0];
            lo_pending_next = 1'b0;
          end
          // R3 bit 7 zero
          `IDX_PEAK: rdata_next[7:0] = {1'b0, stats.peak};
          // R4 upper sum bits
          `IDX_SUMMED: rdata_next[7:0] = stats.sum[`SUM_HI_BIT:`SUM_LO_BIT];
          // R5 bit 7 zero
          `IDX_FLOOR: rdata_next[7:0] = {1'b0, stats.floor};
          `IDX_GRAB: begin
            // R7 consume and advance
            if (grab_state_reg == GRAB_HELD) begin
              rdata_next[7:0] = {1'b1, grab_val_reg};
              grab_state_next = GRAB_ARMED;
              grab_idx_next   = (grab_idx_reg == `PIX_LAST_INDEX) ?
                                `PIX_FIRST_INDEX : grab_idx_reg + 9'd1;
            end
          end
          // R11 complement
          `IDX_FLIPPED_REV: rdata_next[7:0] = ~REV_CODE;
          `IDX_FUSE_SETUP: rdata_next[`FUSE_EN_BIT] = fuse_cmd_enable;
          default: rresp_next = `RESP_SLVERR;
        endcase
      end
    end

    if (do_write && w_mapped && wstrb0_reg) begin
      if (w_idx == `IDX_GRAB) begin
        // R9 restart at zero
        grab_state_next = GRAB_ARMED;
        grab_idx_next   = `PIX_FIRST_INDEX;
      end else begin
        // R12 fuse gate
        fuse_next = wdata_reg[`FUSE_EN_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_reg     <= 1'b0;
      w_held_reg      <= 1'b0;
      waddr_reg       <= '0;
      wdata_reg       <= 32'h0000_0000;
      wstrb0_reg      <= 1'b0;
      s_axi_awready   <= 1'b0;
      s_axi_wready    <= 1'b0;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= `RESP_OKAY;
      s_axi_arready   <= 1'b0;
      s_axi_rvalid    <= 1'b0;
      s_axi_rdata     <= 32'h0000_0000;
      s_axi_rresp     <= `RESP_OKAY;
      rd_idx_reg      <= 8'h00;
      grab_state_reg  <= GRAB_IDLE;
      grab_idx_reg    <= `PIX_FIRST_INDEX;
      grab_val_reg    <= 7'h00;
      fuse_cmd_enable <= 1'b0;
      lo_shadow_reg   <= 8'h00;
      lo_pending_reg  <= 1'b0;
    end else begin
      aw_held_reg     <= aw_held_next;
      w_held_reg      <= w_held_next;
      waddr_reg       <= waddr_next;
      wdata_reg       <= wdata_next;
      wstrb0_reg      <= wstrb0_next;
      // one slot per channel; ready drops while a beat is held
      s_axi_awready   <= !aw_held_next;
      s_axi_wready    <= !w_held_next;
      s_axi_bvalid    <= bvalid_next;
      s_axi_bresp     <= bresp_next;
      s_axi_arready   <= !rvalid_next;
      s_axi_rvalid    <= rvalid_next;
      s_axi_rdata     <= rdata_next;
      s_axi_rresp     <= rresp_next;
      rd_idx_reg      <= ar_take ? r_idx : rd_idx_reg;
      grab_state_reg  <= grab_state_next;
      grab_idx_reg    <= grab_idx_next;
      grab_val_reg    <= grab_val_next;
      fuse_cmd_enable <= fuse_next;
      lo_shadow_reg   <= lo_shadow_next;
      lo_pending_reg  <= lo_pending_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  exposure_latch_a: assert property ( // R1
    open_d_reg && !shutter_open |=> exposure_reg == $past(cnt_reg))
    else $error("exposure count not latched on close");

  peak_bit7_a: assert property ( // R3
    ar_take && r_addr_ok && r_idx == `IDX_PEAK
      |=> s_axi_rvalid && s_axi_rdata[7:0] == {1'b0, $past(stats.peak)})
    else $error("peak read wrong");

  summed_bits_a: assert property ( // R4
    ar_take && r_addr_ok && r_idx == `IDX_SUMMED
      |=> s_axi_rdata[7:0] == $past(stats.sum[15:8]))
    else $error("summed read wrong");

  floor_bit7_a: assert property ( // R5
    s_axi_rvalid && rd_idx_reg == `IDX_FLOOR && s_axi_rresp == `RESP_OKAY |-> !s_axi_rdata[7])
    else $error("floor bit 7 set");

  grab_held_a: assert property ( // R6
    grab_state_reg == GRAB_HELD && !(do_write && w_idx == `IDX_GRAB) && !ar_take
      |=> grab_state_reg == GRAB_HELD && $stable(grab_val_reg))
    else $error("held pixel lost");

  grab_read_a: assert property ( // R7
    ar_take && r_addr_ok && r_idx == `IDX_GRAB && grab_state_reg == GRAB_HELD &&
      !(do_write && wstrb0_reg && w_mapped && w_idx == `IDX_GRAB)
      |=> s_axi_rdata[7:0] == {1'b1, $past(grab_val_reg)} && grab_state_reg == GRAB_ARMED
          && (grab_idx_reg == $past(grab_idx_reg) + 9'd1 || grab_idx_reg == 9'd0))
    else $error("grab read did not advance");

  grab_write_a: assert property ( // R9
    do_write && w_mapped && wstrb0_reg && w_idx == `IDX_GRAB
      |=> grab_idx_reg == 9'd0 && grab_state_reg == GRAB_ARMED)
    else $error("grab write did not rearm");

  flipped_rev_a: assert property ( // R11
    ar_take && r_addr_ok && r_idx == `IDX_FLIPPED_REV |=> s_axi_rdata[7:0] == ~REV_CODE)
    else $error("flipped revision wrong");

  fuse_gate_a: assert property ( // R12
    do_write && w_mapped && wstrb0_reg && w_idx == `IDX_FUSE_SETUP
      |=> fuse_cmd_enable == $past(wdata_reg[0]))
    else $error("fuse enable not written");

  lower_frozen_a: assert property ( // R13
    ar_take && r_addr_ok && r_idx == `IDX_EXPOSURE_UPPER |=> lo_pending_reg
      && lo_shadow_reg == $past(exposure_reg[7:0]))
    else $error("lower byte not frozen");

  grab_capture_c: cover property (grab_state_reg == GRAB_ARMED ##1 grab_state_reg == GRAB_HELD);
  grab_wrap_c: cover property (ar_take && r_idx == `IDX_GRAB && grab_idx_reg == `PIX_LAST_INDEX
                                 && grab_state_reg == GRAB_HELD);
  split_read_c: cover property (ar_take && r_idx == `IDX_EXPOSURE_UPPER ##[1:20]
                                  ar_take && r_idx == `IDX_EXPOSURE_LOWER);

endmodule // image_stats_pixel_grabber

// ===== image_stats_defs.svh
`ifndef IMAGE_STATS_DEFS_SVH
`define IMAGE_STATS_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_REVISION        8'h01
`define IDX_EXPOSURE_UPPER  8'h08
`define IDX_EXPOSURE_LOWER  8'h09
`define IDX_PEAK            8'h0A
`define IDX_SUMMED          8'h0B
`define IDX_FLOOR           8'h0C
`define IDX_GRAB            8'h0D
`define IDX_FLIPPED_REV     8'h40
`define IDX_FUSE_SETUP      8'h51

`define EXPOSURE_RESET      16'h0064
`define PEAK_RESET          7'h00
`define FLOOR_RESET         7'h00
`define SUM_RESET           17'h00000
`define FUSE_EN_BIT         0
`define GRAB_VALID_BIT      7
`define SUM_HI_BIT          15
`define SUM_LO_BIT          8

`define PIX_LAST_INDEX      9'd360
`define PIX_FIRST_INDEX     9'd0
`define PIXEL_CEILING       7'h7F
`define ADDR_W              12
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ===== image_stats_pkg.sv
package image_stats_pkg;

  typedef struct packed {
    logic       valid;
    logic [6:0] value;
  } pixel_in_t;

  typedef struct packed {
    logic [6:0]  peak;
    logic [6:0]  floor;
    logic [16:0] sum;
  } frame_stats_t;

  typedef enum logic [1:0] {
    GRAB_IDLE  = 2'b00,
    GRAB_ARMED = 2'b01,
    GRAB_HELD  = 2'b10
  } grab_state_t;

endpackage

// ===== pixel_stats_engine.sv
`timescale 1ns/1ps
`include "image_stats_defs.svh"

module pixel_stats_engine import image_stats_pkg::*; (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         frame_start,
  input  wire pixel_in_t    pix,
  output logic [8:0]        pix_index,
  output frame_stats_t      stats
);

  logic [8:0]   idx_reg, idx_next;
  logic [6:0]   max_reg, max_next;
  logic [6:0]   min_reg, min_next;
  logic [16:0]  sum_reg, sum_next;
  frame_stats_t stats_reg, stats_next;
  logic [8:0]   base_idx;
  logic [6:0]   base_max;
  logic [6:0]   base_min;
  logic [16:0]  base_sum;

  always_comb begin
    base_idx   = frame_start ? `PIX_FIRST_INDEX : idx_reg;
    base_max   = frame_start ? 7'h00 : max_reg;
    base_min   = frame_start ? `PIXEL_CEILING : min_reg;
    base_sum   = frame_start ? `SUM_RESET : sum_reg;
    idx_next   = base_idx;
    max_next   = base_max;
    min_next   = base_min;
    sum_next   = base_sum;
    stats_next = stats_reg;
    // pixels past the last index are dropped until the next frame
    if (pix.valid && base_idx <= `PIX_LAST_INDEX) begin
      idx_next = base_idx + 9'd1;
      max_next = (pix.value > base_max) ? pix.value : base_max;
      min_next = (pix.value < base_min) ? pix.value : base_min;
      // R4 full sum
      sum_next = base_sum + {10'h000, pix.value};
      if (base_idx == `PIX_LAST_INDEX) begin
        // R3 publish peak
        stats_next.peak  = max_next;
        // R5 publish floor
        stats_next.floor = min_next;
        stats_next.sum   = sum_next;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idx_reg   <= `PIX_LAST_INDEX + 9'd1;
      max_reg   <= 7'h00;
      min_reg   <= `PIXEL_CEILING;
      sum_reg   <= `SUM_RESET;
      stats_reg <= '{peak: `PEAK_RESET, floor: `FLOOR_RESET, sum: `SUM_RESET};
    end else begin
      idx_reg   <= idx_next;
      max_reg   <= max_next;
      min_reg   <= min_next;
      sum_reg   <= sum_next;
      stats_reg <= stats_next;
    end
  end

  assign pix_index = base_idx;
  assign stats     = stats_reg;

endmodule // pixel_stats_engine

// ===== image_stats_pixel_grabber_tb.sv
`timescale 1ns/1ps
`include "image_stats_defs.svh"

`define CHECK_EQ(got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); end end

module image_stats_pixel_grabber_tb import image_stats_pkg::*; ;
  // arbitrary value
  localparam logic [7:0] REV = 8'h3C;
  logic               clk = 1'h0;
  logic               rst_n = 1'h0;
  logic               main_tick = 1'h0;
  logic               shutter_open = 1'h0;
  logic               frame_start = 1'h0;
  pixel_in_t          pix = '0;
  logic               fuse_cmd_enable;
  logic [`ADDR_W-1:0] s_axi_awaddr = '0;
  logic [`ADDR_W-1:0] s_axi_araddr = '0;
  logic [31:0]        s_axi_wdata = '0;
  logic [31:0]        s_axi_rdata;
  logic [3:0]         s_axi_wstrb = 4'hF;
  logic               s_axi_awvalid = 1'h0;
  logic               s_axi_wvalid = 1'h0;
  logic               s_axi_bready = 1'h0;
  logic               s_axi_arvalid = 1'h0;
  logic               s_axi_rready = 1'h0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  int                 error_cnt = 0;
  int                 comparisons = 0;

  image_stats_pixel_grabber #(.REV_CODE(REV)) DUT (.clk, .rst_n, .main_tick, .shutter_open,
    .frame_start, .pix, .fuse_cmd_enable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  always #2 clk = ~clk;

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    // one idle edge, so a back-to-back call never re-raises bready in the same step
    @(posedge clk);
    r = 2'h3;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    r = 2'h3;
    d = 'x;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) begin
        r = s_axi_rresp;
        d = s_axi_rdata;
        s_axi_rready <= 1'h0;
        break;
      end
    end
  endtask

  // slave errors carry no defined data, so only the response is judged then
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHECK_EQ(r, er)
    if (er === `RESP_OKAY) `CHECK_EQ(d, e)
  endtask

  task automatic chk_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic [1:0] r;
    wr(a, d, s, r);
    `CHECK_EQ(r, er)
  endtask

  function automatic logic [6:0] pv(input int i, input int k);
    return 7'(20 + (i * k) % 90);
  endfunction

  // one pixel a cycle, in index order down the columns
  task automatic send_frame(input int k);
    for (int i = 0; i < 361; i++) begin
      frame_start <= (i == 0);
      pix <= '{valid: 1'h1, value: pv(i, k)};
      @(posedge clk);
    end
    frame_start <= 1'h0;
    pix <= '0;
    repeat (3) @(posedge clk);
  endtask

  task automatic expose(input int n);
    shutter_open <= 1'h1;
    repeat (n) begin
      main_tick <= 1'h1;
      @(posedge clk);
      main_tick <= 1'h0;
      @(posedge clk);
    end
    shutter_open <= 1'h0;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_reset();
    chk_rd(12'h020, 32'h0, `RESP_OKAY);
    chk_rd(12'h024, 32'h64, `RESP_OKAY);
    chk_rd(12'h028, 32'h0, `RESP_OKAY);
    chk_rd(12'h02C, 32'h0, `RESP_OKAY);
    chk_rd(12'h030, 32'h0, `RESP_OKAY);
    chk_rd(12'h034, 32'h0, `RESP_OKAY);
    chk_rd(12'h144, 32'h0, `RESP_OKAY);
    chk_rd(12'h004, 32'(REV), `RESP_OKAY);
    chk_rd(12'h100, {24'h000000, ~REV}, `RESP_OKAY);
    chk_rd(12'h400, 32'h0, `RESP_SLVERR);
    chk_wr(12'h028, 32'h55, 4'hF, `RESP_SLVERR);
    chk_rd(12'h028, 32'h0, `RESP_OKAY);
    chk_wr(12'h3FC, 32'h1, 4'hF, `RESP_SLVERR);
    $display("test reset done");
  endtask

  task automatic t_fuse();
    `CHECK_EQ(fuse_cmd_enable, 1'h0)
    chk_wr(12'h144, 32'h1, 4'hF, `RESP_OKAY);
    `CHECK_EQ(fuse_cmd_enable, 1'h1)
    chk_rd(12'h144, 32'h1, `RESP_OKAY);
    chk_wr(12'h144, 32'h0, 4'h0, `RESP_OKAY);
    `CHECK_EQ(fuse_cmd_enable, 1'h1)
    chk_wr(12'h144, 32'h0, 4'hF, `RESP_OKAY);
    `CHECK_EQ(fuse_cmd_enable, 1'h0)
    $display("test fuse done");
  endtask

  task automatic t_stats();
    logic [6:0]  mx;
    logic [6:0]  mn;
    logic [16:0] sum;
    mx = 7'h0;
    mn = 7'h7F;
    sum = 17'h0;
    for (int i = 0; i < 361; i++) begin
      if (pv(i, 1) > mx) mx = pv(i, 1);
      if (pv(i, 1) < mn) mn = pv(i, 1);
      sum = sum + 17'(pv(i, 1));
    end
    send_frame(1);
    chk_rd(12'h028, 32'(mx), `RESP_OKAY);
    chk_rd(12'h030, 32'(mn), `RESP_OKAY);
    chk_rd(12'h02C, 32'(sum[15:8]), `RESP_OKAY);
    $display("test stats done");
  endtask

  // software keeps only top-bit reads, one per index
  task automatic t_grab();
    chk_wr(12'h034, 32'hA5, 4'hF, `RESP_OKAY);
    chk_rd(12'h034, 32'h0, `RESP_OKAY);
    send_frame(3);
    chk_rd(12'h034, 32'h80 | 32'(pv(0, 3)), `RESP_OKAY);
    chk_rd(12'h034, 32'h0, `RESP_OKAY);
    send_frame(5);
    send_frame(7);
    chk_rd(12'h034, 32'h80 | 32'(pv(1, 5)), `RESP_OKAY);
    send_frame(7);
    chk_wr(12'h034, 32'h0, 4'hF, `RESP_OKAY);
    chk_rd(12'h034, 32'h0, `RESP_OKAY);
    send_frame(9);
    chk_rd(12'h034, 32'h80 | 32'(pv(0, 9)), `RESP_OKAY);
    send_frame(9);
    chk_rd(12'h034, 32'h80 | 32'(pv(1, 9)), `RESP_OKAY);
    $display("test grab done");
  endtask

  task automatic t_expo();
    repeat (3) begin
      main_tick <= 1'h1;
      @(posedge clk);
      main_tick <= 1'h0;
      @(posedge clk);
    end
    expose(300);
    // upper byte first keeps both halves from one measurement
    chk_rd(12'h020, 32'h01, `RESP_OKAY);
    chk_rd(12'h024, 32'h2C, `RESP_OKAY);
    expose(517);
    chk_rd(12'h020, 32'h02, `RESP_OKAY);
    expose(100);
    chk_rd(12'h024, 32'h05, `RESP_OKAY);
    chk_rd(12'h024, 32'h64, `RESP_OKAY);
    $display("test exposure done");
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // tests need about 5000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    $display("ERROR t=%0t watchdog expired", $time);
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    t_reset();
    t_fuse();
    t_stats();
    t_grab();
    t_expo();
    end_sim();
  end
endmodule // image_stats_pixel_grabber_tb
